// *** common/exdac_pkg.sv ***
// Package of register map, field layout and timing constants for the DAC.
package exdac_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          CODE_W          = 12;
  // Register byte addresses.
  localparam logic [15:0] ADDR_DAC_CFG    = 16'h2010;
  localparam logic [15:0] ADDR_DAC_CODE   = 16'h2048;
  localparam logic [15:0] ADDR_PWR_BW     = 16'h2100;
  localparam logic [15:0] ADDR_SRC_CTRL   = 16'h2104;
  localparam logic [15:0] ADDR_WG_FREQ    = 16'h2108;
  localparam logic [15:0] ADDR_WG_LEVEL   = 16'h210c;
  localparam logic [15:0] ADDR_WG_PHASE   = 16'h2110;
  localparam logic [15:0] ADDR_STATUS     = 16'h2114;
  // Reset values.
  localparam logic [12:0] DAC_CFG_RST     = 13'h001e;
  localparam logic [11:0] DAC_CODE_RST    = 12'h800;
  localparam logic [3:0]  PWR_BW_RST      = 4'h4;
  localparam logic [3:0]  SRC_CTRL_RST    = 4'h8;
  localparam logic [10:0] WG_AMP_RST      = 11'h000;
  // Field positions.
  localparam int          CFG_ATTEN_BIT   = 0;
  localparam int          CFG_RATE_LSB    = 1;
  localparam int          CFG_RATE_MSB    = 8;
  localparam int          CFG_GAIN_BIT    = 12;
  localparam int          PB_HIPWR_BIT    = 0;
  localparam int          PB_FILT_LSB     = 2;
  localparam int          PB_FILT_MSB     = 3;
  localparam int          SC_SRC_BIT      = 0;
  localparam int          SC_WAVE_LSB     = 1;
  localparam int          SC_WAVE_MSB     = 2;
  localparam int          SC_CLKEN_BIT    = 3;
  localparam int          LV_OFS_LSB      = 16;
  // Code limits of the DAC string.
  localparam logic [11:0] CODE_MID        = 12'h800;
  localparam logic [11:0] CODE_MIN        = 12'h200;
  localparam logic [11:0] CODE_MAX        = 12'he00;
  // ADC sample divider from analog clock: 16 MHz / 800 kSPS.
  localparam int          ACLK_LP_HZ      = 16_000_000;
  localparam int          ADC_LP_SPS      = 800_000;
  localparam logic [4:0]  ADC_DIV         = 5'(ACLK_LP_HZ / ADC_LP_SPS);
  typedef enum logic [1:0] {
    WAVE_SINE   = 2'b00,
    WAVE_TRAP   = 2'b01,
    WAVE_SQUARE = 2'b10
  } exdac_wave_t;
  typedef enum logic [1:0] {
    APB_IDLE  = 2'b00,
    APB_READY = 2'b01
  } exdac_apb_t;
endpackage : exdac_pkg

// *** common/exdac_wave_if.sv ***
// Interface between the DAC controller and its waveform generator.
`timescale 1ns/100ps
interface exdac_wave_if;
  logic        enable;
  logic        tick;
  logic [1:0]  wave;
  logic [15:0] freq;
  logic [15:0] phase;
  logic [10:0] amp;
  logic [11:0] ofs;
  logic [11:0] code;
  modport ctl (output enable, tick, wave, freq, phase, amp, ofs,
               input code);
  modport gen (input enable, tick, wave, freq, phase, amp, ofs,
               output code);
endinterface : exdac_wave_if

// *** rtl/exdac_top.sv ***
// Excitation DAC controller: APB registers, update divider, code source.
`timescale 1ns/100ps
module exdac_top (
  input  wire logic        I_CLK_SYS,      // System clock, 200 MHz.
  input  wire logic        I_NRST,         // Asynchronous reset, low.
  input  wire logic [15:0] I_PADDR,        // APB address.
  input  wire logic        I_PSEL,         // APB select.
  input  wire logic        I_PENABLE,      // APB enable.
  input  wire logic        I_PWRITE,       // APB direction.
  input  wire logic [31:0] I_PWDATA,       // APB write data.
  input  wire logic        I_ACLK_TICK,    // One pulse per analog clock.
  input  wire logic        I_HIBERNATE,    // Device is in hibernate.
  output logic      [31:0] O_PRDATA,       // APB read data.
  output logic             O_PREADY,       // APB ready.
  output logic             O_PSLVERR,      // APB error, unmapped.
  output logic      [11:0] O_DAC_CODE,     // Code to the DAC string.
  output logic             O_DAC_UPDATE,   // Pulse when code updates.
  output logic             O_ADC_SAMPLE,   // Pulse per ADC sample.
  output logic             O_DAC_CLK_EN,   // Gate for DAC clocks.
  output logic             O_HIGH_POWER,   // High power mode select.
  output logic      [1:0]  O_FILTER_SEL,   // Reconstruction filter.
  output logic             O_ATTEN_EN,     // Attenuator, gain 0.2.
  output logic             O_AMP_GAIN_SEL  // Amplifier gain 0.25.
);
  typedef struct packed {
    exdac_pkg::exdac_apb_t st;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [12:0] dac_cfg;
    logic [11:0] dac_code;
    logic [3:0]  pwr_bw;
    logic [3:0]  src_ctrl;
    logic [15:0] wg_freq;
    logic [11:0] wg_ofs;
    logic [10:0] wg_amp;
    logic [15:0] wg_phase;
    logic [7:0]  div_cnt;
    logic [4:0]  adc_cnt;
    logic        upd;
    logic        adc;
    logic [11:0] out_code;
    logic        clk_en;
  } exdac_state_t;

  exdac_state_t s_q, s_d;
  exdac_wave_if wv ();
  logic         clk_run;
  logic         aclk;
  logic [7:0]   rate_eff;
  logic         fire;
  logic         setup;
  logic         commit;

  function automatic logic [11:0] clamp_code(input logic [11:0] c);
    if (c < exdac_pkg::CODE_MIN)
      return exdac_pkg::CODE_MIN;
    else if (c > exdac_pkg::CODE_MAX)
      return exdac_pkg::CODE_MAX;
    return c;
  endfunction : clamp_code

  assign clk_run  = s_q.src_ctrl[exdac_pkg::SC_CLKEN_BIT] && !I_HIBERNATE;
  assign aclk     = I_ACLK_TICK && clk_run;
  assign rate_eff = (s_q.dac_cfg[exdac_pkg::CFG_RATE_MSB:
                                 exdac_pkg::CFG_RATE_LSB] == 8'h00) ? 8'h01
                  : s_q.dac_cfg[exdac_pkg::CFG_RATE_MSB:
                                exdac_pkg::CFG_RATE_LSB];
  assign fire     = aclk && (8'(s_q.div_cnt + 8'h01) >= rate_eff);
  assign setup    = I_PSEL && !I_PENABLE && (s_q.st == exdac_pkg::APB_IDLE);
  assign commit   = I_PSEL && I_PENABLE && (s_q.st == exdac_pkg::APB_READY);

  assign wv.enable = s_q.src_ctrl[exdac_pkg::SC_SRC_BIT] && clk_run;
  assign wv.tick   = fire;
  assign wv.wave   = s_q.src_ctrl[exdac_pkg::SC_WAVE_MSB:
                                  exdac_pkg::SC_WAVE_LSB];
  assign wv.freq   = s_q.wg_freq;
  assign wv.phase  = s_q.wg_phase;
  assign wv.amp    = s_q.wg_amp;
  assign wv.ofs    = s_q.wg_ofs;

  exdac_wavegen u_gen (
    .i_clk  (I_CLK_SYS),
    .i_nrst (I_NRST),
    .wv     (wv.gen)
  );

  always_comb begin
    s_d        = s_q;
    s_d.upd    = 1'b0;
    s_d.adc    = 1'b0;
    s_d.clk_en = clk_run;
    // Zero-wait APB: ready rises in the first access cycle.
    case (s_q.st)
      exdac_pkg::APB_IDLE: begin
        if (setup) begin
          s_d.st      = exdac_pkg::APB_READY;
          s_d.pready  = 1'b1;
          s_d.pslverr = 1'b0;
          s_d.prdata  = 32'h0000_0000;
          case (I_PADDR)
            exdac_pkg::ADDR_DAC_CFG:  s_d.prdata = 32'(s_q.dac_cfg);
            exdac_pkg::ADDR_DAC_CODE: s_d.prdata = 32'(s_q.dac_code);
            exdac_pkg::ADDR_PWR_BW:   s_d.prdata = 32'(s_q.pwr_bw);
            exdac_pkg::ADDR_SRC_CTRL: s_d.prdata = 32'(s_q.src_ctrl);
            exdac_pkg::ADDR_WG_FREQ:  s_d.prdata = 32'(s_q.wg_freq);
            exdac_pkg::ADDR_WG_LEVEL:
              s_d.prdata = {4'h0, s_q.wg_ofs, 5'h00, s_q.wg_amp};
            exdac_pkg::ADDR_WG_PHASE: s_d.prdata = 32'(s_q.wg_phase);
            exdac_pkg::ADDR_STATUS:
              s_d.prdata = 32'({s_q.clk_en, s_q.out_code});
            default:                  s_d.pslverr = 1'b1;
          endcase
        end
      end
      exdac_pkg::APB_READY: begin
        if (commit) begin
          s_d.st      = exdac_pkg::APB_IDLE;
          s_d.pready  = 1'b0;
          s_d.pslverr = 1'b0;
          if (I_PWRITE) begin
            case (I_PADDR)
              exdac_pkg::ADDR_DAC_CFG:  s_d.dac_cfg  = I_PWDATA[12:0];
              exdac_pkg::ADDR_DAC_CODE: s_d.dac_code = I_PWDATA[11:0];
              exdac_pkg::ADDR_PWR_BW:   s_d.pwr_bw   = I_PWDATA[3:0];
              exdac_pkg::ADDR_SRC_CTRL: s_d.src_ctrl = I_PWDATA[3:0];
              exdac_pkg::ADDR_WG_FREQ:  s_d.wg_freq  = I_PWDATA[15:0];
              exdac_pkg::ADDR_WG_LEVEL: begin
                s_d.wg_amp = I_PWDATA[10:0];
                s_d.wg_ofs = I_PWDATA[exdac_pkg::LV_OFS_LSB +: 12];
              end
              exdac_pkg::ADDR_WG_PHASE: s_d.wg_phase = I_PWDATA[15:0];
              default: ;
            endcase
          end
        end
      end
      default: begin
        s_d.st     = exdac_pkg::APB_IDLE;
        s_d.pready = 1'b0;
      end
    endcase
    if (aclk) begin
      s_d.div_cnt = fire ? 8'h00 : 8'(s_q.div_cnt + 8'h01);
      if (s_q.adc_cnt == 5'(exdac_pkg::ADC_DIV - 5'h01)) begin
        s_d.adc_cnt = 5'h00;
        s_d.adc     = 1'b1;
      end else begin
        s_d.adc_cnt = 5'(s_q.adc_cnt + 5'h01);
      end
    end
    if (fire) begin
      s_d.upd      = 1'b1;
      s_d.out_code = s_q.src_ctrl[exdac_pkg::SC_SRC_BIT] ? wv.code
                   : clamp_code(s_q.dac_code);
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      s_q          <= '0;
      s_q.st       <= exdac_pkg::APB_IDLE;
      s_q.dac_cfg  <= exdac_pkg::DAC_CFG_RST;
      s_q.dac_code <= exdac_pkg::DAC_CODE_RST;
      s_q.pwr_bw   <= exdac_pkg::PWR_BW_RST;
      s_q.src_ctrl <= exdac_pkg::SRC_CTRL_RST;
      s_q.wg_amp   <= exdac_pkg::WG_AMP_RST;
      s_q.wg_ofs   <= exdac_pkg::CODE_MID;
      s_q.out_code <= exdac_pkg::CODE_MID;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_PRDATA       = s_q.prdata;
  assign O_PREADY       = s_q.pready;
  assign O_PSLVERR      = s_q.pslverr;
  assign O_DAC_CODE     = s_q.out_code;
  assign O_DAC_UPDATE   = s_q.upd;
  assign O_ADC_SAMPLE   = s_q.adc;
  assign O_DAC_CLK_EN   = s_q.clk_en;
  assign O_HIGH_POWER   = s_q.pwr_bw[exdac_pkg::PB_HIPWR_BIT];
  assign O_FILTER_SEL   = s_q.pwr_bw[exdac_pkg::PB_FILT_MSB:
                                     exdac_pkg::PB_FILT_LSB];
  assign O_ATTEN_EN     = s_q.dac_cfg[exdac_pkg::CFG_ATTEN_BIT];
  assign O_AMP_GAIN_SEL = s_q.dac_cfg[exdac_pkg::CFG_GAIN_BIT];

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);

  sequence s_setup;
    setup;
  endsequence
  sequence s_answer;
    O_PREADY ##1 !O_PREADY;
  endsequence

  a_code_range: assert property (
    O_DAC_CODE >= exdac_pkg::CODE_MIN && O_DAC_CODE <= exdac_pkg::CODE_MAX)
    else $error("code out of range");
  a_direct_src: assert property (
    fire && !s_q.src_ctrl[exdac_pkg::SC_SRC_BIT]
    |=> O_DAC_UPDATE && O_DAC_CODE == clamp_code($past(s_q.dac_code)))
    else $error("direct code not shown");
  a_gen_src: assert property (
    fire && s_q.src_ctrl[exdac_pkg::SC_SRC_BIT]
    |=> O_DAC_CODE == $past(wv.code))
    else $error("generator code not shown");
  a_hib_gate: assert property (
    I_HIBERNATE |=> !O_DAC_CLK_EN && !O_DAC_UPDATE)
    else $error("clock not gated in hibernate");
  a_rate_space: assert property (
    O_DAC_UPDATE && rate_eff >= 8'h02 && !commit |-> !fire)
    else $error("update spacing too short");
  a_adc_period: assert property (
    O_ADC_SAMPLE |-> s_q.adc_cnt == 5'h00
      && $past(s_q.adc_cnt) == 5'(exdac_pkg::ADC_DIV - 5'h01))
    else $error("ADC period wrong");
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("APB answer not one cycle");
  a_pwr_write: assert property (
    commit && I_PWRITE && I_PADDR == exdac_pkg::ADDR_PWR_BW
    |=> O_HIGH_POWER == $past(I_PWDATA[exdac_pkg::PB_HIPWR_BIT]))
    else $error("power bit not applied");
  a_gain_write: assert property (
    commit && I_PWRITE && I_PADDR == exdac_pkg::ADDR_DAC_CFG
    |=> O_AMP_GAIN_SEL == $past(I_PWDATA[exdac_pkg::CFG_GAIN_BIT])
      && O_ATTEN_EN == $past(I_PWDATA[exdac_pkg::CFG_ATTEN_BIT]))
    else $error("gain selects not applied");
endmodule : exdac_top

// *** rtl/exdac_wavegen.sv ***
// Phase-accumulator waveform generator for sine, trapezoid and square.
`timescale 1ns/100ps
module exdac_wavegen (
  input wire logic i_clk,   // System clock.
  input wire logic i_nrst,  // Asynchronous reset, active low.
  exdac_wave_if.gen wv      // Settings in, generated code out.
);
  typedef struct packed {
    logic [15:0] acc;
    logic [11:0] code;
  } exdac_gen_t;
  exdac_gen_t s_q, s_d;
  logic [15:0] p;
  logic [14:0] x;
  logic [29:0] prod;
  logic [13:0] tri_v;
  logic [11:0] shape;
  logic [22:0] mag;
  logic [13:0] val;
  logic        sine;

  always_comb begin
    s_d  = s_q;
    sine = (wv.wave == exdac_pkg::WAVE_SINE);
    // Phase and offset adjust only the sine shape.
    p     = sine ? 16'(s_q.acc + wv.phase) : s_q.acc;
    x     = p[14:0];
    prod  = 30'(x) * 30'(15'h7fff - x);
    tri_v = p[14] ? ~p[13:0] : p[13:0];
    case (wv.wave)
      exdac_pkg::WAVE_SINE:   shape = prod[28:17];
      exdac_pkg::WAVE_TRAP:   shape = tri_v[13] ? exdac_pkg::CODE_MID
                                              : {1'b0, tri_v[12:2]};
      exdac_pkg::WAVE_SQUARE: shape = exdac_pkg::CODE_MID;
      default:                shape = 12'h000;
    endcase
    // Amplitude of 0x600 reaches the code limits; the clamp keeps
    // larger settings inside the DAC string.
    mag = 23'(shape) * 23'(wv.amp);
    val = 14'(sine ? wv.ofs : exdac_pkg::CODE_MID);
    val = p[15] ? 14'(val - 14'(mag[22:11])) : 14'(val + 14'(mag[22:11]));
    if (!wv.enable) begin
      s_d.acc  = 16'h0000;
      s_d.code = exdac_pkg::CODE_MID;
    end else if (wv.tick) begin
      s_d.acc = 16'(s_q.acc + wv.freq);
      if (val[13])
        s_d.code = exdac_pkg::CODE_MIN;
      else if (val < 14'(exdac_pkg::CODE_MIN))
        s_d.code = exdac_pkg::CODE_MIN;
      else if (val > 14'(exdac_pkg::CODE_MAX))
        s_d.code = exdac_pkg::CODE_MAX;
      else
        s_d.code = val[11:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '{acc: 16'h0000, code: exdac_pkg::CODE_MID};
    end else begin
      s_q <= s_d;
    end
  end

  assign wv.code = s_q.code;
endmodule : exdac_wavegen

// *** verif/excitation_dac_control_test.sv ***
// Self-checking testbench of the excitation DAC controller.
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module excitation_dac_control_test;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        hib = 1'b0;
  logic [7:0]  period = 8'h01;
  logic        tick, pready, pslverr, upd, adcs, clken, hp, atten, gain;
  logic [31:0] prdata, rd;
  logic [11:0] code, lo, hi;
  logic [1:0]  filt;
  logic        err;
  int          bad, n, err_total = 0, n_tests = 0;
  int          rt[3] = '{7, 27, 7};
  int          pd[3] = '{1, 2, 1};
  int          pm[3] = '{13, 8, 13};
  logic [11:0] cin[5] = '{12'h100, 12'hfff, 12'he00, 12'h200, 12'h800};
  logic [11:0] cex[5] = '{12'h200, 12'he00, 12'he00, 12'h200, 12'h800};

  always #2.5 clk = ~clk;

  exdac_top dut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_PADDR(paddr),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PWDATA(pwdata), .I_ACLK_TICK(tick), .I_HIBERNATE(hib),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_DAC_CODE(code), .O_DAC_UPDATE(upd), .O_ADC_SAMPLE(adcs),
    .O_DAC_CLK_EN(clken), .O_HIGH_POWER(hp), .O_FILTER_SEL(filt),
    .O_ATTEN_EN(atten), .O_AMP_GAIN_SEL(gain));
  exdac_aclk_model partner (.i_clk(clk), .i_nrst(nrst), .i_period(period),
    .i_code(code), .i_update(upd), .o_tick(tick), .o_bad(bad));

  task give_verdict;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // The slave may stretch the access phase; the master only waits.
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits for the next update or sample pulse, then counts the gap.
  task gap(input logic adc);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((adc ? adcs : upd) !== 1'b1 && n < 400);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((adc ? adcs : upd) !== 1'b1 && n < 400);
  endtask : gap

  task tend(input string s);
    $display("test %s finished", s);
  endtask : tend

  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    `CHK("code_rst", 12'h800, code)
    apb(0, exdac_pkg::ADDR_DAC_CFG, 0);
    `CHK("cfg_rst", 32'h1e, rd)
    apb(0, exdac_pkg::ADDR_DAC_CODE, 0);
    `CHK("code_reg_rst", 32'h800, rd)
    apb(0, exdac_pkg::ADDR_PWR_BW, 0);
    `CHK("pwr_rst", 32'h4, rd)
    apb(0, 16'h2200, 0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    tend("reset");
    for (int f = 1; f < 4; f++) begin
      apb(1, exdac_pkg::ADDR_PWR_BW, 32'((f << 2) | (f & 1)));
      repeat (2) @(posedge clk);
      `CHK("filter", 2'(f), filt)
      `CHK("high_power", 1'(f & 1), hp)
    end
    apb(1, exdac_pkg::ADDR_DAC_CFG, 32'h101f);
    repeat (2) @(posedge clk);
    `CHK("atten_on", 1'b1, atten)
    `CHK("gain_on", 1'b1, gain)
    apb(1, exdac_pkg::ADDR_DAC_CFG, 32'h1e);
    repeat (2) @(posedge clk);
    `CHK("atten_off", 1'b0, atten)
    `CHK("gain_off", 1'b0, gain)
    tend("modes");
    for (int i = 0; i < 5; i++) begin
      apb(1, exdac_pkg::ADDR_DAC_CODE, {20'h0, cin[i]});
      gap(0);
      `CHK("direct_code", cex[i], code)
    end
    apb(1, exdac_pkg::ADDR_STATUS, 32'hfff);
    `CHK("status_wr_err", 1'b0, err)
    apb(0, exdac_pkg::ADDR_STATUS, 0);
    `CHK("status_code", 13'h1800, rd[12:0])
    tend("direct");
    // Power mode, rate and tick spacing go together.
    for (int i = 0; i < 3; i++) begin
      period <= 8'(pd[i]);
      apb(1, exdac_pkg::ADDR_PWR_BW, 32'(pm[i]));
      apb(1, exdac_pkg::ADDR_DAC_CFG, 32'(rt[i] << 1));
      gap(0);
      gap(0);
      `CHK("update_gap", rt[i] * pd[i], n)
      `CHK("rate_mode", 1'(pm[i] & 1), hp)
    end
    period <= 8'h01;
    gap(1);
    `CHK("adc_gap", 20, n)
    tend("rates");
    hib <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("hib_clk", 1'b0, clken)
    n = 0;
    repeat (60) begin
      @(posedge clk);
      if (upd === 1'b1) n++;
    end
    `CHK("hib_updates", 0, n)
    hib <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("wake_clk", 1'b1, clken)
    apb(1, exdac_pkg::ADDR_SRC_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("gate_clk", 1'b0, clken)
    tend("gating");
    apb(1, exdac_pkg::ADDR_WG_LEVEL, 32'h0800_0600);
    apb(1, exdac_pkg::ADDR_WG_FREQ, 32'h1000);
    apb(1, exdac_pkg::ADDR_WG_PHASE, 32'h4000);
    apb(0, exdac_pkg::ADDR_WG_PHASE, 0);
    `CHK("phase_rd", 32'h4000, rd)
    apb(0, exdac_pkg::ADDR_WG_LEVEL, 0);
    `CHK("level_rd", 32'h0800_0600, rd)
    for (int w = 0; w < 3; w++) begin
      apb(1, exdac_pkg::ADDR_SRC_CTRL, 32'(9 | (w << 1)));
      gap(0);
      lo = 12'hfff;
      hi = 12'h000;
      repeat (40) begin
        gap(0);
        if (code < lo) lo = code;
        if (code > hi) hi = code;
      end
      `CHK("wave_low", 1'b1, lo >= 12'h200)
      `CHK("wave_high", 1'b1, hi <= 12'he00)
      `CHK("wave_moves", 1'b1, hi > lo)
      // Full amplitude square swings between the two code limits.
      if (w == 2) begin
        `CHK("square_low", 12'h200, lo)
        `CHK("square_high", 12'he00, hi)
      end
    end
    `CHK("partner_range", 0, bad)
    tend("generator");
    give_verdict();
  end
endmodule : excitation_dac_control_test

// *** verif/exdac_aclk_model.sv ***
// Analog clock tick source and DAC code monitor beside the controller.
`timescale 1ns/100ps
module exdac_aclk_model (
  input  wire logic        i_clk,     // System clock.
  input  wire logic        i_nrst,    // Reset, active low.
  input  wire logic [7:0]  i_period,  // System cycles per analog tick.
  input  wire logic [11:0] i_code,    // Code presented to the DAC.
  input  wire logic        i_update,  // Code update pulse.
  output logic             o_tick,    // Analog clock tick pulse.
  output int               o_bad      // Count of out-of-range codes.
);
  logic [7:0] cnt_q;

  // Ticks stand for an undivided oscillator clock.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q  <= 8'h00;
      o_tick <= 1'b0;
    end else if (cnt_q + 8'h01 >= i_period) begin
      cnt_q  <= 8'h00;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 8'h01;
      o_tick <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst)
      o_bad <= 0;
    else if (i_update && (i_code < 12'h200 || i_code > 12'he00))
      o_bad <= o_bad + 1;
  end
endmodule : exdac_aclk_model
